// ===== inc/fbc_pkg.sv
// constants, field positions and operation codes of the four-bit controller core
// assumes an outside decoder turns fetched bytes into fbc_op_e codes
package fbc_pkg;
    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int          PC_W      = 11;
    localparam int          STK_DEPTH = 3;
    localparam logic [10:0] PC_RST    = 11'h000;
    localparam logic [10:0] IRQ_VEC   = 11'h0FF;
    localparam logic [1:0]  PULSE_MIN = 2'h2;
    localparam logic [3:0]  NIB_RST   = 4'h0;
    localparam logic [7:0]  BYTE_RST  = 8'h00;
    localparam logic [7:0]  TMR_MAX   = 8'hFF;
    // ------------------------------------------------------------
    // feature_select_register bit positions
    // ------------------------------------------------------------
    localparam int EN_CNT  = 0;
    localparam int EN_IRQ  = 1;
    localparam int EN_PORT = 2;
    localparam int EN_SO   = 3;
    // ------------------------------------------------------------
    // decoded operations
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_NOP  = 5'h00, OP_JUMP = 5'h01, OP_CALL = 5'h02, OP_RET  = 5'h03,
        OP_ASC  = 5'h04, OP_ADD  = 5'h05, OP_CLRA = 5'h06, OP_LBI  = 5'h07,
        OP_LEI  = 5'h08, OP_XAS  = 5'h09, OP_LOAD_TIMER_FROM_ACC_MEM = 5'h0A, OP_STORE_TIMER_TO_ACC_MEM = 5'h0B,
        OP_INL  = 5'h0C, OP_OBD  = 5'h0D, OP_CAMQ = 5'h0E, OP_SKT  = 5'h0F,
        OP_LD   = 5'h10, OP_ST   = 5'h11
    } fbc_op_e;
endpackage : fbc_pkg

// ===== hdl/fbc_core.sv
// datapath and sequencing of the four-bit controller core
// assumes one clk edge per instruction cycle and a decoder presenting op_code
//
// Behaviour
// [RQ1] 11-bit program counter steps by one each cycle unless control is transferred.
// [RQ2] three-entry stack pushes next address on call or interrupt, return pops it.
// [RQ3] large variant: 7-bit pointer, 3 row bits and 4 digit bits.
// [RQ4] small variant: 6-bit pointer, 2 row bits and 4 digit bits.
// [RQ5] digit bits of the pointer load the general output register.
// [RQ6] 4-bit adder writes accumulator and its carry into the carry bit.
// [RQ7] 8-bit up timer loads from and stores to memory/accumulator, flags wrap, clears on reset.
// [RQ8] host option turns inputs one, two, three into read, select, write strobes.
// [RQ9] in dual-clock mode output bit zero selects the instruction clock source.
// [RQ10] output latch drives the port when enabled; host write captures the port.
// [RQ11] port pin levels can be read into accumulator and addressed digit.
// [RQ12] exchange swaps serial register with accumulator and copies carry to gate latch.
// [RQ13] feature register written only by load-feature-immediate; here a taken interrupt also clears bit one.
// [RQ14] counter mode: count down on long low pulses, clock pin follows latch.
// [RQ15] outside source holds counting pulses low at least two cycles.
// [RQ16] shift mode: shift left taking serial input, clock pin is latch and clock.
// [RQ17] shift mode: serial output is msb when bit three set, else zero.
// [RQ18] bit one allows interrupts and clears itself when one is taken.
// [RQ19] bit two drives the latch onto the port, cleared releases it.
// [RQ20] interrupt pushes next address dropping oldest entry and jumps to 0FF.
// [RQ21] interrupt needs allow bit, two-cycle low pulse and a finished instruction.
// [RQ22] interrupt waits out chained transfers and chained pointer loads.
// [RQ23] pending skip is stacked with the address and restored on return.
// [RQ24] reset clears pc and registers, sets gate latch, leaves memory alone.
`timescale 1ns/1ps
module fbc_core #(
    parameter int BR_W     = 3,
    parameter bit HOST_OPT = 1'b0,
    parameter bit DUAL_CLK = 1'b0
) (
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire fbc_pkg::fbc_op_e  op_code,
    input  wire logic [7:0]        op_imm,
    input  wire logic [10:0]       op_target,
    output logic      [10:0]       pc,
    output logic      [3:0]        acc,
    output logic                   carry,
    input  wire logic [3:0]        gen_in,
    input  wire logic              serial_in,
    output logic                   serial_out,
    output logic                   shift_clock_pin,
    output logic      [3:0]        gp_out,
    output logic                   clock_choice_latch,
    input  wire logic [7:0]        port_in,
    output logic      [7:0]        port_out,
    output logic                   port_oe,
    output logic                   timer_ovf
);
    localparam int PTR_W = BR_W + 4; // see [RQ3] see [RQ4]

    function automatic logic [1:0] low_cnt(input logic [1:0] c, input logic pin);
        if (pin)
            return 2'h0;
        return (c == fbc_pkg::PULSE_MIN) ? c : c + 2'h1;
    endfunction : low_cnt

    function automatic logic is_xfer(input fbc_pkg::fbc_op_e o);
        return (o == fbc_pkg::OP_JUMP) || (o == fbc_pkg::OP_CALL) || (o == fbc_pkg::OP_RET);
    endfunction : is_xfer

    logic [3:0]       ram [2**PTR_W];
    logic [10:0]      pc_q;
    logic [11:0]      stk_q [fbc_pkg::STK_DEPTH];
    logic             skip_q, prev_xfer_q, prev_lbi_q;
    logic [3:0]       acc_q, sio_q, en_q, d_q;
    logic             c_q, gate_q, phase_q, ovf_q, irq_pend_q;
    logic [PTR_W-1:0] ptr_q;
    logic [7:0]       tmr_q, q_q;
    logic [1:0]       irq_cnt_q, si_cnt_q, irq_cnt_d, si_cnt_d;
    logic             wr_q;
    logic             irq_fire, si_fire, defer, take_irq, host_wr;
    logic [4:0]       sum;
    logic [3:0]       mem;
    logic [10:0]      pc_inc;
    fbc_pkg::fbc_op_e op_x;

    // ------------------------------------------------------------
    // execution control
    // ------------------------------------------------------------
    assign mem       = ram[ptr_q];
    assign pc_inc    = pc_q + 11'h001; // see [RQ1]
    assign sum       = {1'b0, acc_q} + {1'b0, mem} + {4'h0, c_q & (op_x == fbc_pkg::OP_ASC)}; // see [RQ6]
    assign irq_cnt_d = low_cnt(irq_cnt_q, gen_in[1]);
    assign si_cnt_d  = low_cnt(si_cnt_q, serial_in);
    assign irq_fire  = (irq_cnt_d == fbc_pkg::PULSE_MIN) && (irq_cnt_q != fbc_pkg::PULSE_MIN); // see [RQ21]
    assign si_fire   = (si_cnt_d == fbc_pkg::PULSE_MIN) && (si_cnt_q != fbc_pkg::PULSE_MIN); // see [RQ15]
    assign defer     = (prev_xfer_q && is_xfer(op_code)) || (prev_lbi_q && op_code == fbc_pkg::OP_LBI); // see [RQ22]
    assign take_irq  = irq_pend_q && en_q[fbc_pkg::EN_IRQ] && !defer; // see [RQ21]
    assign op_x      = (take_irq || skip_q) ? fbc_pkg::OP_NOP : op_code;
    assign host_wr   = HOST_OPT && !gen_in[2] && !gen_in[3] && wr_q; // see [RQ8]

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_cnt_q <= fbc_pkg::PULSE_MIN;
            si_cnt_q  <= fbc_pkg::PULSE_MIN;
            wr_q      <= 1'b0;
            phase_q   <= 1'b0;
        end else begin
            irq_cnt_q <= irq_cnt_d;
            si_cnt_q  <= si_cnt_d;
            wr_q      <= gen_in[3];
            phase_q   <= !phase_q;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_pend_q <= 1'b0;
        end else if (irq_fire && !HOST_OPT) begin
            irq_pend_q <= 1'b1;
        end else if (take_irq) begin
            irq_pend_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // sequencing: pc, stack, skip, chain tracking
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pc_q <= fbc_pkg::PC_RST; // see [RQ24]
        end else if (take_irq) begin
            pc_q <= fbc_pkg::IRQ_VEC; // see [RQ20]
        end else begin
            case (op_x)
                fbc_pkg::OP_JUMP,
                fbc_pkg::OP_CALL: pc_q <= op_target;
                fbc_pkg::OP_RET:  pc_q <= stk_q[0][10:0]; // see [RQ2]
                default:          pc_q <= pc_inc; // see [RQ1]
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < fbc_pkg::STK_DEPTH; i++)
                stk_q[i] <= 12'h000;
        end else if (take_irq || op_x == fbc_pkg::OP_CALL) begin
            for (int i = fbc_pkg::STK_DEPTH - 1; i > 0; i--)
                stk_q[i] <= stk_q[i-1]; // see [RQ20]
            stk_q[0] <= take_irq ? {skip_q, pc_q} : {1'b0, pc_inc}; // see [RQ2] see [RQ23]
        end else if (op_x == fbc_pkg::OP_RET) begin
            for (int i = 0; i < fbc_pkg::STK_DEPTH - 1; i++)
                stk_q[i] <= stk_q[i+1];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            skip_q      <= 1'b0;
            prev_xfer_q <= 1'b0;
            prev_lbi_q  <= 1'b0;
        end else begin
            prev_xfer_q <= is_xfer(op_x);
            prev_lbi_q  <= (op_x == fbc_pkg::OP_LBI);
            case (op_x)
                fbc_pkg::OP_RET: skip_q <= stk_q[0][11]; // see [RQ23]
                fbc_pkg::OP_ASC: skip_q <= sum[4];
                fbc_pkg::OP_SKT: skip_q <= ovf_q;
                default:         skip_q <= 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // accumulator, carry, pointer, outputs, feature register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            acc_q <= fbc_pkg::NIB_RST;
            c_q   <= 1'b0;
        end else begin
            case (op_x)
                fbc_pkg::OP_ASC: begin
                    acc_q <= sum[3:0]; // see [RQ6]
                    c_q   <= sum[4];
                end
                fbc_pkg::OP_ADD:  acc_q <= sum[3:0];
                fbc_pkg::OP_CLRA: acc_q <= fbc_pkg::NIB_RST;
                fbc_pkg::OP_LD:   acc_q <= mem;
                fbc_pkg::OP_XAS:  acc_q <= sio_q; // see [RQ12]
                fbc_pkg::OP_STORE_TIMER_TO_ACC_MEM: acc_q <= tmr_q[7:4]; // see [RQ7]
                fbc_pkg::OP_INL:  acc_q <= port_in[7:4]; // see [RQ11]
                default:          acc_q <= acc_q;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        case (op_x)
            fbc_pkg::OP_ST:   ram[ptr_q] <= acc_q;
            fbc_pkg::OP_STORE_TIMER_TO_ACC_MEM: ram[ptr_q] <= tmr_q[3:0];
            fbc_pkg::OP_INL:  ram[ptr_q] <= port_in[3:0]; // see [RQ11]
            default:          ram[ptr_q] <= mem;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ptr_q <= '0;
            d_q   <= fbc_pkg::NIB_RST;
            en_q  <= fbc_pkg::NIB_RST;
        end else begin
            if (op_x == fbc_pkg::OP_LBI)
                ptr_q <= op_imm[PTR_W-1:0]; // see [RQ3] see [RQ4]
            if (op_x == fbc_pkg::OP_OBD)
                d_q <= ptr_q[3:0]; // see [RQ5]
            if (op_x == fbc_pkg::OP_LEI)
                en_q <= op_imm[3:0]; // see [RQ13]
            else if (take_irq)
                en_q[fbc_pkg::EN_IRQ] <= 1'b0; // see [RQ18]
        end
    end

    // ------------------------------------------------------------
    // serial register and shift clock gate
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sio_q  <= fbc_pkg::NIB_RST;
            gate_q <= 1'b1; // see [RQ24]
        end else if (op_x == fbc_pkg::OP_XAS) begin
            sio_q  <= acc_q; // see [RQ12]
            gate_q <= c_q;
        end else if (en_q[fbc_pkg::EN_CNT]) begin
            if (si_fire)
                sio_q <= sio_q - 4'h1; // see [RQ14]
        end else begin
            sio_q <= {sio_q[2:0], serial_in}; // see [RQ16]
        end
    end

    // ------------------------------------------------------------
    // timer and output latch
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tmr_q <= fbc_pkg::BYTE_RST; // see [RQ7]
            ovf_q <= 1'b0;
        end else begin
            tmr_q <= (op_x == fbc_pkg::OP_LOAD_TIMER_FROM_ACC_MEM) ? {acc_q, mem} : tmr_q + 8'h01;
            if (op_x != fbc_pkg::OP_LOAD_TIMER_FROM_ACC_MEM && tmr_q == fbc_pkg::TMR_MAX)
                ovf_q <= 1'b1; // see [RQ7]
            else if (op_x == fbc_pkg::OP_SKT)
                ovf_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q_q <= fbc_pkg::BYTE_RST;
        end else if (host_wr) begin
            q_q <= port_in; // see [RQ10]
        end else if (op_x == fbc_pkg::OP_CAMQ) begin
            q_q <= {acc_q, mem};
        end
    end

    // ------------------------------------------------------------
    // pin outputs
    // ------------------------------------------------------------
    assign pc                 = pc_q;
    assign acc                = acc_q;
    assign carry              = c_q;
    assign gp_out             = d_q;
    assign timer_ovf          = ovf_q;
    assign clock_choice_latch = DUAL_CLK && d_q[0]; // see [RQ9]
    assign port_out           = q_q; // see [RQ10]
    assign port_oe            = en_q[fbc_pkg::EN_PORT] || (HOST_OPT && !gen_in[2] && !gen_in[1]); // see [RQ19]
    assign shift_clock_pin    = en_q[fbc_pkg::EN_CNT] ? gate_q : gate_q && phase_q; // see [RQ14] see [RQ16]
    assign serial_out         = en_q[fbc_pkg::EN_SO] && (en_q[fbc_pkg::EN_CNT] || sio_q[3]); // see [RQ17]

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_irq_vector: assert property (@(posedge clk) disable iff (!resetn) // see [RQ20]
        take_irq |=> pc_q == fbc_pkg::IRQ_VEC && stk_q[0][10:0] == $past(pc_q))
        else $error("interrupt did not vector to 0FF");
    a_irq_allow_clr: assert property (@(posedge clk) disable iff (!resetn) // see [RQ18]
        take_irq |=> !en_q[fbc_pkg::EN_IRQ])
        else $error("allow bit still set after interrupt");
    a_call_ret_pair: assert property (@(posedge clk) disable iff (!resetn) // see [RQ2]
        op_x == fbc_pkg::OP_CALL ##1 (op_x == fbc_pkg::OP_RET && !take_irq) |=> pc_q == $past(pc_q, 2) + 11'h001)
        else $error("return did not resume after call");
    a_pc_step: assert property (@(posedge clk) disable iff (!resetn) // see [RQ1]
        !take_irq && !is_xfer(op_x) |=> pc_q == $past(pc_inc))
        else $error("pc did not advance by one");
    a_skip_saved: assert property (@(posedge clk) disable iff (!resetn) // see [RQ23]
        take_irq && skip_q |=> stk_q[0][11])
        else $error("pending skip not stacked");
    a_sio_count: assert property (@(posedge clk) disable iff (!resetn) // see [RQ14]
        en_q[fbc_pkg::EN_CNT] && si_fire && op_x != fbc_pkg::OP_XAS |=> sio_q == $past(sio_q) - 4'h1)
        else $error("serial counter missed a pulse");
    a_sio_shift: assert property (@(posedge clk) disable iff (!resetn) // see [RQ16]
        !en_q[fbc_pkg::EN_CNT] && op_x != fbc_pkg::OP_XAS ##1 !en_q[fbc_pkg::EN_CNT]
        |-> sio_q[0] == $past(serial_in) && sio_q[3:1] == $past(sio_q[2:0]))
        else $error("serial shift wrong");
    a_port_drive: assert property (@(posedge clk) disable iff (!resetn) // see [RQ19]
        op_x == fbc_pkg::OP_LEI && op_imm[fbc_pkg::EN_PORT] |=> port_oe)
        else $error("port not driven after enable");
    a_timer_wrap: assert property (@(posedge clk) disable iff (!resetn) // see [RQ7]
        tmr_q == fbc_pkg::TMR_MAX && op_x != fbc_pkg::OP_LOAD_TIMER_FROM_ACC_MEM |=> ovf_q && tmr_q == fbc_pkg::BYTE_RST)
        else $error("timer wrap not flagged");
    a_xas_gate: assert property (@(posedge clk) disable iff (!resetn) // see [RQ12]
        op_x == fbc_pkg::OP_XAS |=> gate_q == $past(c_q) && acc_q == $past(sio_q))
        else $error("exchange wrong");
endmodule : fbc_core

// ===== verification/fbc_pulse_src.sv
// far-side model: external pulse source for the serial counting input and interrupt input one
// assumes fire is a one-cycle request from the bench, sampled on the rising clk edge
`timescale 1ns/1ps
module fbc_pulse_src (
    input  wire logic       clk,
    input  wire logic       idle,
    input  wire logic       fire,
    input  wire logic [3:0] low_len,
    output logic            line
);
    logic [3:0] left_q = 4'h0;

    // low pulse never shorter than two cycles, so the device can register it
    always_ff @(posedge clk) begin
        if (fire) begin
            left_q <= (low_len < 4'h2) ? 4'h2 : low_len;
        end else if (left_q != 4'h0) begin
            left_q <= left_q - 4'h1;
        end
    end

    assign line = (left_q != 4'h0) ? 1'b0 : idle;
endmodule : fbc_pulse_src

// ===== verification/four_bit_controller_core_bench.sv
// self-checking bench for the four-bit controller core, driving decoded ops directly
// assumes fbc_pkg is compiled first and fbc_pulse_src stands in for the pulse sources
`timescale 1ns/1ps
module four_bit_controller_core_bench;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic             clk       = 1'b0;
    logic             resetn    = 1'b0;
    fbc_pkg::fbc_op_e op_code   = fbc_pkg::OP_NOP;
    logic [7:0]       op_imm    = 8'h00;
    logic [10:0]      op_target = 11'h000;
    logic [7:0]       port_in   = 8'h00;
    logic             s_idle    = 1'b0;
    logic             s_fire    = 1'b0;
    logic             i_fire    = 1'b0;
    logic [3:0]       p_len     = 4'h3;
    logic [3:0]       h_gen     = 4'hF;
    logic [7:0]       h_port;
    logic             h_oe;
    logic             serial_in;
    logic             irq_line;
    logic [3:0]       gen_in;
    logic [10:0]      pc;
    logic [3:0]       acc;
    logic [3:0]       gp_out;
    logic [7:0]       port_out;
    logic             carry;
    logic             serial_out;
    logic             shift_clock_pin;
    logic             clock_choice_latch;
    logic             port_oe;
    logic             timer_ovf;
    int               fails     = 0;
    int               n_tests   = 0;

    always #4 clk = ~clk;
    assign gen_in = {2'b11, irq_line, 1'b1};

    fbc_core #(.BR_W(3), .HOST_OPT(1'b0), .DUAL_CLK(1'b1)) dut_u (
        .clk(clk), .resetn(resetn), .op_code(op_code), .op_imm(op_imm), .op_target(op_target),
        .pc(pc), .acc(acc), .carry(carry), .gen_in(gen_in), .serial_in(serial_in),
        .serial_out(serial_out), .shift_clock_pin(shift_clock_pin), .gp_out(gp_out),
        .clock_choice_latch(clock_choice_latch), .port_in(port_in), .port_out(port_out),
        .port_oe(port_oe), .timer_ovf(timer_ovf)
    );
    // small variant with the host strobe option, sharing the op stream
    fbc_core #(.BR_W(2), .HOST_OPT(1'b1), .DUAL_CLK(1'b0)) host_u (
        .clk(clk), .resetn(resetn), .op_code(op_code), .op_imm(op_imm), .op_target(op_target),
        .pc(), .acc(), .carry(), .gen_in(h_gen), .serial_in(serial_in), .serial_out(), .shift_clock_pin(),
        .gp_out(), .clock_choice_latch(), .port_in(port_in), .port_out(h_port), .port_oe(h_oe), .timer_ovf()
    );
    fbc_pulse_src ser_u (.clk(clk), .idle(s_idle), .fire(s_fire), .low_len(p_len), .line(serial_in));
    fbc_pulse_src irq_u (.clk(clk), .idle(1'b1), .fire(i_fire), .low_len(p_len), .line(irq_line));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %0h expected %0h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic op(input fbc_pkg::fbc_op_e c, input logic [7:0] imm = 8'h00, input logic [10:0] t = 11'h000);
        @(posedge clk);
        op_code   <= c;
        op_imm    <= imm;
        op_target <= t;
    endtask : op

    // lets the last op execute, then samples once it has landed
    task automatic settle();
        op(fbc_pkg::OP_NOP);
        #1;
    endtask : settle

    task automatic watch(input int n, output int ones, output int skh);
        ones = 0;
        skh  = 0;
        repeat (n) begin
            ones += int'(serial_out === 1'b1);
            skh  += int'(shift_clock_pin === 1'b1);
            @(posedge clk);
            #1;
        end
    endtask : watch

    task automatic kick(input bit irq);
        @(posedge clk);
        if (irq) i_fire <= 1'b1;
        else s_fire <= 1'b1;
        @(posedge clk);
        i_fire <= 1'b0;
        s_fire <= 1'b0;
    endtask : kick

    task automatic done(input string s);
        $display("test %s done", s);
    endtask : done

    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3000) @(posedge clk);
        fails++;
        finish_test();
    end

    initial begin
        int          p;
        int          ones;
        int          skh;
        logic [10:0] rp;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        #1;
        chk(pc, 11'h000, "pc after reset");
        chk({acc, carry, gp_out, port_oe, serial_out}, 11'h000, "registers after reset");
        chk(11'({port_out, timer_ovf}), 11'h000, "latch and overflow after reset");
        done("reset");
        p = int'(pc);
        settle();
        chk(pc, 11'(p + 1), "pc steps by one");
        p = int'(pc);
        for (int i = 1; i < 4; i++) op(fbc_pkg::OP_CALL, 8'h00, 11'(i * 256));
        repeat (3) op(fbc_pkg::OP_RET);
        settle();
        chk(pc, 11'(p + 2), "three level return");
        done("stack");
        @(posedge clk) port_in <= 8'hA5;
        op(fbc_pkg::OP_INL);
        op(fbc_pkg::OP_ASC);
        op(fbc_pkg::OP_ASC);
        op(fbc_pkg::OP_CLRA);
        settle();
        chk(11'({carry, acc}), 11'h014, "add with carry then skip");
        done("adder");
        op(fbc_pkg::OP_LEI, 8'h00);
        op(fbc_pkg::OP_XAS);
        settle();
        chk(11'(acc), 11'h000, "serial into acc");
        watch(8, ones, skh);
        chk(11'(ones), 11'h000, "serial out held low");
        chk(11'(skh > 0 && skh < 8), 11'h001, "shift clock gated by phase");
        op(fbc_pkg::OP_INL);
        op(fbc_pkg::OP_LEI, 8'h08);
        op(fbc_pkg::OP_XAS);
        settle();
        watch(8, ones, skh);
        chk(11'(ones), 11'h002, "msb shifted out");
        done("shift");
        @(posedge clk) s_idle <= 1'b1;
        op(fbc_pkg::OP_LEI, 8'h01);
        op(fbc_pkg::OP_XAS);
        settle();
        watch(4, ones, skh);
        chk(11'(skh), 11'h004, "clock pin follows latch");
        chk(11'(ones), 11'h000, "serial out follows bit three");
        kick(1'b0);
        repeat (6) @(posedge clk);
        op(fbc_pkg::OP_XAS);
        settle();
        chk(11'(acc), 11'h00F, "count down on pulse");
        op(fbc_pkg::OP_LEI, 8'h09);
        settle();
        chk(11'(serial_out), 11'h001, "serial out set by bit three");
        done("counter");
        op(fbc_pkg::OP_LBI, 8'h37);
        op(fbc_pkg::OP_OBD);
        settle();
        chk(11'({clock_choice_latch, gp_out}), 11'h017, "digit bits to output");
        op(fbc_pkg::OP_LEI, 8'h04);
        settle();
        chk(11'({port_oe, port_out}), 11'h100, "port driven");
        op(fbc_pkg::OP_LEI, 8'h00);
        settle();
        chk(11'(port_oe), 11'h000, "port released");
        done("outputs");
        @(posedge clk) port_in <= 8'hFE;
        op(fbc_pkg::OP_INL);
        op(fbc_pkg::OP_LOAD_TIMER_FROM_ACC_MEM);
        settle();
        p = 0;
        while (timer_ovf !== 1'b1 && p < 4) begin
            @(posedge clk);
            #1;
            p++;
        end
        chk(11'(p), 11'h002, "timer wraps after two counts");
        op(fbc_pkg::OP_SKT);
        op(fbc_pkg::OP_CLRA);
        settle();
        chk(11'({timer_ovf, acc}), 11'h00F, "overflow skip clears flag");
        done("timer");
        op(fbc_pkg::OP_JUMP, 8'h00, 11'h400);
        settle();
        chk(pc, 11'h400, "jump target");
        // the carrying add sets a skip one cycle before the interrupt is taken, so the skip is still pending and gets stacked
        op(fbc_pkg::OP_LEI, 8'h02);
        kick(1'b1);
        op(fbc_pkg::OP_ASC);
        op(fbc_pkg::OP_NOP);
        #1;
        rp = pc;
        p  = 0;
        while (pc !== 11'h0FF && p < 10) begin
            @(posedge clk);
            #1;
            p++;
        end
        chk(pc, 11'h0FF, "interrupt vector");
        op(fbc_pkg::OP_RET);
        op(fbc_pkg::OP_CLRA);
        settle();
        chk(pc, rp + 11'h001, "interrupt return address");
        chk(11'(acc), 11'h00E, "stacked skip restored");
        kick(1'b1);
        p = 0;
        repeat (10) begin
            @(posedge clk);
            #1;
            if (pc === 11'h0FF) p++;
        end
        chk(11'(p), 11'h000, "second interrupt blocked");
        done("interrupt");
        op(fbc_pkg::OP_CLRA);
        op(fbc_pkg::OP_LOAD_TIMER_FROM_ACC_MEM);
        op(fbc_pkg::OP_STORE_TIMER_TO_ACC_MEM);
        op(fbc_pkg::OP_CAMQ);
        op(fbc_pkg::OP_ADD);
        op(fbc_pkg::OP_ADD);
        op(fbc_pkg::OP_ST);
        op(fbc_pkg::OP_CLRA);
        op(fbc_pkg::OP_LD);
        settle();
        chk(11'(port_out), 11'h00E, "timer read back through latch");
        chk(11'({carry, acc}), 11'h01C, "add keeps carry, store and load");
        done("transfers");
        @(posedge clk) begin
            port_in <= 8'h5A;
            h_gen   <= 4'h3;
        end
        @(posedge clk) h_gen <= 4'h9;
        #1;
        chk(11'({h_oe, h_port}), 11'h15A, "host write then read");
        @(posedge clk) h_gen <= 4'hF;
        #1;
        chk(11'(h_oe), 11'h000, "host read released");
        done("host");
        finish_test();
    end
endmodule : four_bit_controller_core_bench
